// ---- core/snr_config_routing.sv ----
`timescale 1ns/100ps
// How it works
// - Registers reachable only via configuration transactions
// - Identity: chip id, boot pins, revision, version
// - Description: links, cores, links per processor
// - Write lock bit refuses all writes
// - Multiplier lock bit ignores settings writes
// - Header bit selects single-byte headers, network-wide
// - Writable 16-bit node id, MSB-first compare
// - Route by highest mismatching bit's direction
// - Low table: positions 7..0, four bits each
// - High table: positions 15..8, four bits each
// - Accepted settings write resets attached tile
// - Multiplier fields reset from boot pins
// - Switch clock is input over divider plus one
// - Reference clock over divider plus one, reset 3
// - Link direction field selects outgoing links
module snr_config_routing
    import snr_pkg::*;
#(
    parameter int unsigned NUM_LINKS = 8,
    parameter logic [7:0] CHIP_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] SWITCH_REV = 8'h01, // Arbitrary value
    parameter logic [7:0] SWITCH_VER = 8'h01, // Arbitrary value
    parameter logic [7:0] NUM_CORES = 8'h01,
    parameter logic [7:0] LINKS_PER_CORE = 8'h04
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic boot_select_pin_a_i,
    input wire logic boot_select_pin_b_i,
    input wire logic cfg_req_i,
    input wire logic cfg_write_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic [DATA_W-1:0] cfg_wdata_i,
    output logic cfg_ack_o,
    output logic cfg_err_o,
    output logic [DATA_W-1:0] cfg_rdata_o,
    input wire logic route_req_i,
    input wire logic [NODE_ID_W-1:0] route_dest_i,
    output logic route_valid_o,
    output logic route_local_o,
    output logic [DIR_W-1:0] route_dir_o,
    output logic [NUM_LINKS-1:0] route_link_mask_o,
    output logic header_short_o,
    output logic tile_reset_o,
    output logic [PLL_OD_W-1:0] pll_od_o,
    output logic [PLL_F_W-1:0] pll_f_o,
    output logic [PLL_R_W-1:0] pll_r_o,
    output logic switch_clk_en_o,
    output logic ref_clk_en_o
);

    localparam logic [7:0] LINK_COUNT = 8'(NUM_LINKS);
    localparam int unsigned RST_CNT_W = $clog2(TILE_RST_CYC + 1);

    // Highest set bit of a mismatch vector; zero vector gives zero
    function automatic logic [3:0] msb_index(input logic [NODE_ID_W-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < NODE_ID_W; i++) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Direction code stored for one mismatch position
    function automatic logic [DIR_W-1:0] dir_of(input logic [3:0] pos,
                                                 input logic [31:0] lo,
                                                 input logic [31:0] hi);
        logic [2:0] slot;
        slot = pos[2:0];
        if (pos[3]) begin
            return hi[slot*DIR_W +: DIR_W];
        end
        return lo[slot*DIR_W +: DIR_W];
    endfunction

    // Inclusive address range test, for the link bank and the per-link banks not built in this block
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic wlock_reg;
    logic plock_reg;
    logic hdr_reg;
    logic [NODE_ID_W-1:0] node_id_reg;
    logic [CLKDIV_W-1:0] swdiv_reg;
    logic [CLKDIV_W-1:0] refdiv_reg;
    logic [31:0] dir_lo_reg;
    logic [31:0] dir_hi_reg;
    logic [DIR_W-1:0] link_dir_reg [NUM_LINKS];
    logic [1:0] mode_reg;
    logic strap_done_reg;
    logic [RST_CNT_W-1:0] rst_cnt_reg;
    logic wr_ok;
    logic pll_wr;
    logic known_addr;
    logic ro_addr;
    logic [2:0] link_sel;
    logic link_addr;
    logic [DATA_W-1:0] rdata_next;
    logic [NODE_ID_W-1:0] mismatch;
    logic [3:0] hit_pos;
    logic [DIR_W-1:0] hit_dir;
    logic [NUM_LINKS-1:0] link_match;

    // Address decode; unknown indices answer with an error
    always_comb begin
        link_addr = in_range(cfg_addr_i, IDX_LINK_FIRST, IDX_LINK_LAST);
        link_sel = cfg_addr_i[2:0];
        ro_addr = (cfg_addr_i == IDX_IDENT) || (cfg_addr_i == IDX_DESC)
            || (cfg_addr_i == IDX_DBGSRC);
        known_addr = ro_addr || link_addr
            || (cfg_addr_i == IDX_SWCFG) || (cfg_addr_i == IDX_NODEID)
            || (cfg_addr_i == IDX_PLL) || (cfg_addr_i == IDX_SWDIV)
            || (cfg_addr_i == IDX_REFDIV) || (cfg_addr_i == IDX_DIRLO)
            || (cfg_addr_i == IDX_DIRHI) || (cfg_addr_i == IDX_DBGPIN)
            || in_range(cfg_addr_i, IDX_PLINK_FIRST, IDX_PLINK_LAST)
            || in_range(cfg_addr_i, IDX_LCFG_FIRST, IDX_LCFG_LAST)
            || in_range(cfg_addr_i, IDX_LSTAT_FIRST, IDX_LSTAT_LAST);
    end

    // A write lands only if the bank is unlocked and the target is writable
    assign wr_ok = cfg_req_i && cfg_write_i && known_addr && !ro_addr
        && !wlock_reg;
    assign pll_wr = wr_ok && (cfg_addr_i == IDX_PLL) && !plock_reg;

    // Boot pins are caught on the first edge after reset release
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            mode_reg <= {boot_select_pin_b_i, boot_select_pin_a_i};
            strap_done_reg <= 1'b1;
        end
    end

    // Lock and header bits; once the write lock is set only reset clears it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wlock_reg <= 1'b0;
            plock_reg <= 1'b0;
            hdr_reg <= 1'b0;
        end else if (wr_ok && (cfg_addr_i == IDX_SWCFG)) begin
            wlock_reg <= cfg_wdata_i[SWCFG_WLOCK_BIT];
            plock_reg <= cfg_wdata_i[SWCFG_PLOCK_BIT];
            hdr_reg <= cfg_wdata_i[SWCFG_HDR_BIT];
        end
    end

    // Node identifier
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            node_id_reg <= NODEID_RST;
        end else if (wr_ok && (cfg_addr_i == IDX_NODEID)) begin
            node_id_reg <= cfg_wdata_i[NODE_ID_W-1:0];
        end
    end

    // Multiplier settings: constant under reset, strap values right after
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_od_o <= '0;
            pll_f_o <= '0;
            pll_r_o <= '0;
        end else if (!strap_done_reg) begin
            pll_od_o <= PLL_OD_BY_MODE[{boot_select_pin_b_i, boot_select_pin_a_i}*PLL_OD_W
                +: PLL_OD_W];
            pll_f_o <= PLL_F_BY_MODE[{boot_select_pin_b_i, boot_select_pin_a_i}*PLL_F_W
                +: PLL_F_W];
            pll_r_o <= PLL_R_BY_MODE[{boot_select_pin_b_i, boot_select_pin_a_i}*PLL_R_W
                +: PLL_R_W];
        end else if (pll_wr) begin
            pll_od_o <= cfg_wdata_i[PLL_OD_LSB +: PLL_OD_W];
            pll_f_o <= cfg_wdata_i[PLL_F_LSB +: PLL_F_W];
            pll_r_o <= cfg_wdata_i[PLL_R_LSB +: PLL_R_W];
        end
    end

    // Tile reset is stretched so the tile sees a clean pulse of fixed length
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_cnt_reg <= '0;
            tile_reset_o <= 1'b0;
        end else if (pll_wr) begin
            rst_cnt_reg <= RST_CNT_W'(TILE_RST_CYC - 1);
            tile_reset_o <= 1'b1;
        end else if (rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
            tile_reset_o <= 1'b1;
        end else begin
            tile_reset_o <= 1'b0;
        end
    end

    // Clock dividers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            swdiv_reg <= SWDIV_RST;
            refdiv_reg <= REFDIV_RST;
        end else if (wr_ok && (cfg_addr_i == IDX_SWDIV)) begin
            swdiv_reg <= cfg_wdata_i[CLKDIV_W-1:0];
        end else if (wr_ok && (cfg_addr_i == IDX_REFDIV)) begin
            refdiv_reg <= cfg_wdata_i[CLKDIV_W-1:0];
        end
    end

    // Direction tables
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_lo_reg <= DIR_TAB_RST;
            dir_hi_reg <= DIR_TAB_RST;
        end else if (wr_ok && (cfg_addr_i == IDX_DIRLO)) begin
            dir_lo_reg <= cfg_wdata_i;
        end else if (wr_ok && (cfg_addr_i == IDX_DIRHI)) begin
            dir_hi_reg <= cfg_wdata_i;
        end
    end

    // Per-link direction fields; the other link status bits live elsewhere
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                link_dir_reg[i] <= LINK_DIR_RST;
            end
        end else if (wr_ok && link_addr && (int'(link_sel) < NUM_LINKS)) begin
            link_dir_reg[link_sel] <= cfg_wdata_i[LINK_DIR_LSB +: DIR_W];
        end
    end

    // Read mux; reserved bits and banks not built here read as zero
    always_comb begin
        rdata_next = '0;
        case (cfg_addr_i)
            IDX_IDENT: begin
                rdata_next[IDENT_CHIP_LSB +: 8] = CHIP_ID;
                rdata_next[IDENT_MODE_LSB +: 2] = mode_reg;
                rdata_next[IDENT_REV_LSB +: 8] = SWITCH_REV;
                rdata_next[IDENT_VER_LSB +: 8] = SWITCH_VER;
            end
            IDX_DESC: begin
                rdata_next[DESC_LINKS_LSB +: 8] = LINK_COUNT;
                rdata_next[DESC_CORES_LSB +: 8] = NUM_CORES;
                rdata_next[DESC_LPP_LSB +: 8] = LINKS_PER_CORE;
            end
            IDX_SWCFG: begin
                rdata_next[SWCFG_WLOCK_BIT] = wlock_reg;
                rdata_next[SWCFG_PLOCK_BIT] = plock_reg;
                rdata_next[SWCFG_HDR_BIT] = hdr_reg;
            end
            IDX_NODEID: begin
                rdata_next[NODE_ID_W-1:0] = node_id_reg;
            end
            IDX_PLL: begin
                rdata_next[PLL_OD_LSB +: PLL_OD_W] = pll_od_o;
                rdata_next[PLL_F_LSB +: PLL_F_W] = pll_f_o;
                rdata_next[PLL_R_LSB +: PLL_R_W] = pll_r_o;
            end
            IDX_SWDIV: begin
                rdata_next[CLKDIV_W-1:0] = swdiv_reg;
            end
            IDX_REFDIV: begin
                rdata_next[CLKDIV_W-1:0] = refdiv_reg;
            end
            IDX_DIRLO: begin
                rdata_next = dir_lo_reg;
            end
            IDX_DIRHI: begin
                rdata_next = dir_hi_reg;
            end
            default: begin
                if (link_addr && (int'(link_sel) < NUM_LINKS)) begin
                    rdata_next[LINK_DIR_LSB +: DIR_W] = link_dir_reg[link_sel];
                end
            end
        endcase
    end

    // One answer per request, one cycle later; refused writes flag an error
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_ack_o <= 1'b0;
            cfg_err_o <= 1'b0;
            cfg_rdata_o <= '0;
        end else begin
            cfg_ack_o <= cfg_req_i;
            cfg_err_o <= cfg_req_i && (!known_addr
                || (cfg_write_i && (ro_addr || wlock_reg))
                || (cfg_write_i && (cfg_addr_i == IDX_PLL) && plock_reg));
            cfg_rdata_o <= (cfg_req_i && !cfg_write_i) ? rdata_next : '0;
        end
    end

    // Routing decision: XOR finds mismatches, highest one picks the table slot
    always_comb begin
        mismatch = route_dest_i ^ node_id_reg;
        hit_pos = msb_index(mismatch);
        hit_dir = dir_of(hit_pos, dir_lo_reg, dir_hi_reg);
    end

    // Links whose direction field matches the chosen direction
    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_link_match
        assign link_match[g] = (link_dir_reg[g] == hit_dir);
    end

    // Registered routing answer, one cycle after the request
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            route_valid_o <= 1'b0;
            route_local_o <= 1'b0;
            route_dir_o <= '0;
            route_link_mask_o <= '0;
        end else begin
            route_valid_o <= route_req_i;
            if (route_req_i && (mismatch == '0)) begin
                route_local_o <= 1'b1;
                route_dir_o <= '0;
                route_link_mask_o <= '0;
            end else if (route_req_i) begin
                route_local_o <= 1'b0;
                route_dir_o <= hit_dir;
                route_link_mask_o <= link_match;
            end else begin
                route_local_o <= 1'b0;
                route_dir_o <= '0;
                route_link_mask_o <= '0;
            end
        end
    end

    // Header mode straight from its flip-flop
    assign header_short_o = hdr_reg;

    // Switch clock enable
    snr_clk_div #(
        .WIDTH(CLKDIV_W)
    ) u_switch_div (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .div_i(swdiv_reg),
        .tick_o(switch_clk_en_o)
    );

    // Reference clock enable
    snr_clk_div #(
        .WIDTH(CLKDIV_W)
    ) u_ref_div (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .div_i(refdiv_reg),
        .tick_o(ref_clk_en_o)
    );

endmodule

// ---- core/snr_pkg.sv ----
package snr_pkg;

    // Register bus shape
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register indices as printed
    localparam logic [7:0] IDX_IDENT = 8'h00;
    localparam logic [7:0] IDX_DESC = 8'h01;
    localparam logic [7:0] IDX_SWCFG = 8'h04;
    localparam logic [7:0] IDX_NODEID = 8'h05;
    localparam logic [7:0] IDX_PLL = 8'h06;
    localparam logic [7:0] IDX_SWDIV = 8'h07;
    localparam logic [7:0] IDX_REFDIV = 8'h08;
    localparam logic [7:0] IDX_DIRLO = 8'h0C;
    localparam logic [7:0] IDX_DIRHI = 8'h0D;
    localparam logic [7:0] IDX_DBGPIN = 8'h10;
    localparam logic [7:0] IDX_DBGSRC = 8'h1F;
    localparam logic [7:0] IDX_LINK_FIRST = 8'h20;
    localparam logic [7:0] IDX_LINK_LAST = 8'h27;
    localparam logic [7:0] IDX_PLINK_FIRST = 8'h40;
    localparam logic [7:0] IDX_PLINK_LAST = 8'h43;
    localparam logic [7:0] IDX_LCFG_FIRST = 8'h80;
    localparam logic [7:0] IDX_LCFG_LAST = 8'h87;
    localparam logic [7:0] IDX_LSTAT_FIRST = 8'hA0;
    localparam logic [7:0] IDX_LSTAT_LAST = 8'hA7;

    // Field positions
    localparam int unsigned IDENT_CHIP_LSB = 24;
    localparam int unsigned IDENT_MODE_LSB = 16;
    localparam int unsigned IDENT_REV_LSB = 8;
    localparam int unsigned IDENT_VER_LSB = 0;
    localparam int unsigned DESC_LINKS_LSB = 16;
    localparam int unsigned DESC_CORES_LSB = 8;
    localparam int unsigned DESC_LPP_LSB = 0;
    localparam int unsigned SWCFG_WLOCK_BIT = 31;
    localparam int unsigned SWCFG_PLOCK_BIT = 8;
    localparam int unsigned SWCFG_HDR_BIT = 0;
    localparam int unsigned PLL_OD_LSB = 23;
    localparam int unsigned PLL_OD_W = 3;
    localparam int unsigned PLL_F_LSB = 8;
    localparam int unsigned PLL_F_W = 13;
    localparam int unsigned PLL_R_LSB = 0;
    localparam int unsigned PLL_R_W = 7;
    localparam int unsigned NODE_ID_W = 16;
    localparam int unsigned CLKDIV_W = 16;
    localparam int unsigned DIR_W = 4;
    localparam int unsigned LINK_DIR_LSB = 8;

    // Reset values
    localparam logic [15:0] NODEID_RST = 16'h0000;
    localparam logic [15:0] SWDIV_RST = 16'h0000;
    localparam logic [15:0] REFDIV_RST = 16'h0003;
    localparam logic [31:0] DIR_TAB_RST = 32'h0000_0000;
    localparam logic [3:0] LINK_DIR_RST = 4'h0;

    // Multiplier settings chosen by the boot pins, index {pin_b, pin_a}
    localparam logic [11:0] PLL_OD_BY_MODE = 12'h249;
    localparam logic [51:0] PLL_F_BY_MODE = 52'h0031_F013_F007_F;
    localparam logic [27:0] PLL_R_BY_MODE = 28'h0000_000;

    // Tile reset hold time
    localparam int unsigned CLK_FREQ_MHZ = 125;
    localparam int unsigned TILE_RST_NS = 64;
    localparam int unsigned TILE_RST_CYC = (TILE_RST_NS * CLK_FREQ_MHZ + 999) / 1000;

endpackage

// ---- core/snr_clk_div.sv ----
`timescale 1ns/100ps
module snr_clk_div
    import snr_pkg::*;
#(
    parameter int unsigned WIDTH = CLKDIV_W
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] div_i,
    output logic tick_o
);

    logic [WIDTH-1:0] count_reg;

    // Counts 0..div_i, so the tick rate is the input clock over div_i + 1
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else if (count_reg >= div_i) begin
            count_reg <= '0; // A shrunken divider restarts at once instead of wrapping
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Tick is registered so the enable leaves a flip-flop
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= (count_reg >= div_i);
        end
    end

endmodule

// ---- dv/snr_config_routing_chk.sv ----
`timescale 1ns/100ps
// Port-level watcher for the register bus and routing answers
module snr_config_routing_chk
    import snr_pkg::*;
#(
    parameter int unsigned NUM_LINKS = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cfg_req_i,
    input wire logic cfg_write_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic cfg_ack_o,
    input wire logic cfg_err_o,
    input wire logic [DATA_W-1:0] cfg_rdata_o,
    input wire logic route_req_i,
    input wire logic route_valid_o,
    input wire logic route_local_o,
    input wire logic [DIR_W-1:0] route_dir_o,
    input wire logic [NUM_LINKS-1:0] route_link_mask_o,
    input wire logic header_short_o,
    input wire logic tile_reset_o,
    input wire logic [PLL_F_W-1:0] pll_f_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    logic pll_wr;
    logic sw_wr;
    // Decoded writes; the only legal causes of tile reset and header change
    assign pll_wr = cfg_req_i && cfg_write_i && cfg_addr_i == IDX_PLL;
    assign sw_wr = cfg_req_i && cfg_write_i && cfg_addr_i == IDX_SWCFG;

    ack_follows_a: assert property (cfg_req_i |=> cfg_ack_o)
        else $error("ack missing after request");
    ack_alone_a: assert property (!cfg_req_i |=> !cfg_ack_o && cfg_rdata_o == '0)
        else $error("answer without request");
    unmapped_err_a: assert property (cfg_req_i && cfg_addr_i == 8'h02 |=> cfg_err_o)
        else $error("unmapped index not flagged");
    ro_write_a: assert property (cfg_req_i && cfg_write_i && (cfg_addr_i == IDX_IDENT
        || cfg_addr_i == IDX_DBGSRC) |=> cfg_err_o)
        else $error("identity write accepted");
    ro_err_a: assert property (cfg_req_i && cfg_write_i && cfg_addr_i == IDX_DESC |=> cfg_err_o)
        else $error("read-only write accepted");
    route_answer_a: assert property (route_req_i |=> route_valid_o)
        else $error("route answer missing");
    local_quiet_a: assert property (route_local_o |-> route_valid_o && route_dir_o == '0 &&
        route_link_mask_o == '0)
        else $error("local delivery also forwarded");
    tile_hold_a: assert property ($rose(tile_reset_o) |-> tile_reset_o [*8])
        else $error("tile reset too short");
    tile_cause_a: assert property ($rose(tile_reset_o) |-> $past(pll_wr))
        else $error("tile reset without settings write");
    pll_steady_a: assert property ($past(rst_n_i, 3) && !pll_wr |=> $stable(pll_f_o))
        else $error("settings changed without write");
    header_cause_a: assert property (!$stable(header_short_o) |-> $past(sw_wr))
        else $error("header mode changed without write");

    cover property (route_valid_o && !route_local_o);
    cover property ($rose(tile_reset_o));
    cover property (cfg_ack_o && cfg_err_o);
endmodule

bind snr_config_routing snr_config_routing_chk #(.NUM_LINKS(NUM_LINKS)) i_snr_config_routing_chk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cfg_req_i(cfg_req_i),
    .cfg_write_i(cfg_write_i),
    .cfg_addr_i(cfg_addr_i),
    .cfg_ack_o(cfg_ack_o),
    .cfg_err_o(cfg_err_o),
    .cfg_rdata_o(cfg_rdata_o),
    .route_req_i(route_req_i),
    .route_valid_o(route_valid_o),
    .route_local_o(route_local_o),
    .route_dir_o(route_dir_o),
    .route_link_mask_o(route_link_mask_o),
    .header_short_o(header_short_o),
    .tile_reset_o(tile_reset_o),
    .pll_f_o(pll_f_o)
);

// ---- dv/snr_tile_model.sv ----
`timescale 1ns/100ps
// Processor tile issuing configuration reads and writes, one at a time
module snr_tile_model
    import snr_pkg::*;
(
    input wire logic clock_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output logic req_o,
    output logic write_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o
);
    initial begin
        req_o = 1'b0;
        write_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 32'h0000_0000;
    end
    // One-cycle request; released lines show the inverse so stale values never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic ack, output logic err, output logic [31:0] rd);
        @(posedge clock_i);
        #1;
        req_o = 1'b1;
        write_o = w;
        addr_o = a;
        wdata_o = d;
        @(posedge clock_i);
        #1;
        req_o = 1'b0;
        write_o = ~w;
        addr_o = ~a;
        wdata_o = ~d;
        ack = ack_i;
        err = err_i;
        rd = rdata_i;
    endtask
endmodule

// ---- dv/snr_config_routing_tb.sv ----
`timescale 1ns/100ps
// Self-checking bench for the configuration and routing bank
module snr_config_routing_tb import snr_pkg::*;;
    localparam logic [7:0] CID = 8'h3C; // Arbitrary value
    localparam logic [7:0] REV = 8'h07; // Arbitrary value
    localparam logic [7:0] VER = 8'h02; // Arbitrary value
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic pin_a = 1'b0, pin_b = 1'b0;
    logic route_req = 1'b0;
    logic [15:0] dest = 16'h0000;
    logic req, wr, ack, err, rv, rl, hs, tr, sce, rce;
    logic [7:0] addr, lm;
    logic [3:0] dir;
    logic [31:0] wd, rd;
    logic [2:0] od;
    logic [12:0] f;
    logic [6:0] r;
    logic [31:0] mdl [int];
    logic [31:0] seed = 32'h0001_0A98;
    int regs[$] = '{0, 1, 2, 5, 7, 8, 12, 13, 16, 31, 32, 35, 39, 64, 67, 128, 135, 160, 167, 200};
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    always #4 clock_i = ~clock_i;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    snr_config_routing #(.NUM_LINKS(8), .CHIP_ID(CID), .SWITCH_REV(REV), .SWITCH_VER(VER),
        .NUM_CORES(8'h02), .LINKS_PER_CORE(8'h04)) i_snr_config_routing (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .boot_select_pin_a_i(pin_a), .boot_select_pin_b_i(pin_b),
        .cfg_req_i(req), .cfg_write_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wd),
        .cfg_ack_o(ack), .cfg_err_o(err), .cfg_rdata_o(rd),
        .route_req_i(route_req), .route_dest_i(dest), .route_valid_o(rv),
        .route_local_o(rl), .route_dir_o(dir), .route_link_mask_o(lm),
        .header_short_o(hs), .tile_reset_o(tr), .pll_od_o(od), .pll_f_o(f), .pll_r_o(r),
        .switch_clk_en_o(sce), .ref_clk_en_o(rce));

    snr_tile_model i_snr_tile_model (.clock_i(clock_i), .ack_i(ack), .err_i(err),
        .rdata_i(rd), .req_o(req), .write_o(wr), .addr_o(addr), .wdata_o(wd));

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Top bit marks a mapped index; the rest is what a write may store
    function automatic logic [32:0] wm(input int a);
        case (a) inside
            4: return 33'h1_8000_0101;
            5, 7, 8: return 33'h1_0000_FFFF;
            6: return 33'h1_039F_FF7F;
            12, 13: return 33'h1_FFFF_FFFF;
            [32:39]: return 33'h1_0000_0F00;
            0, 1, 16, 31, [64:67], [128:135], [160:167]: return 33'h1_0000_0000;
            default: return 33'h0_0000_0000;
        endcase
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic end_of_test();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Write and mirror; refused writes leave the reference untouched
    task automatic bw(input int a, input logic [31:0] d);
        logic [32:0] m;
        logic e, k;
        logic [31:0] q;
        int n;
        m = wm(a);
        e = !m[32] || a inside {0, 1, 31} || mdl[4][31] || (a == 6 && mdl[4][8]);
        i_snr_tile_model.xfer(1'b1, a[7:0], d, k, q[0], q);
        chk(k, 1'b1);
        chk(err, e);
        if (!e) mdl[a] = d & m[31:0];
        if (a == 6) begin
            n = 0;
            while (tr && n < 50) begin
                @(posedge clock_i);
                #1;
                n++;
            end
            chk(n, e ? 0 : TILE_RST_CYC);
            chk({6'h00, od, 2'h0, f, 1'h0, r}, mdl[6]);
        end
    endtask

    task automatic br(input int a);
        logic [32:0] m;
        logic k, e;
        logic [31:0] q;
        m = wm(a);
        i_snr_tile_model.xfer(1'b0, a[7:0], 32'h0000_0000, k, e, q);
        chk(k, 1'b1);
        chk(e, !m[32]);
        chk(q, mdl.exists(a) ? mdl[a] : 32'h0000_0000);
    endtask

    // Reference route: highest mismatching bit picks the table nibble
    task automatic rt(input logic [15:0] d);
        logic [15:0] x;
        logic [3:0] ed;
        logic [7:0] em;
        int p;
        x = d ^ mdl[5][15:0];
        p = -1;
        for (int i = 0; i < 16; i++) begin
            if (x[i]) p = i;
        end
        ed = p < 0 ? 4'h0 : p < 8 ? mdl[12][p*4 +: 4] : mdl[13][(p-8)*4 +: 4];
        for (int i = 0; i < 8; i++) begin
            em[i] = p >= 0 && mdl[32+i][11:8] == ed;
        end
        @(posedge clock_i);
        #1;
        route_req = 1'b1;
        dest = d;
        @(posedge clock_i);
        #1;
        route_req = 1'b0;
        dest = ~d;
        chk(rv, 1'b1);
        chk(rl, p < 0);
        chk(dir, ed);
        chk(lm, em);
    endtask

    // Cycles between two enable pulses
    task automatic per(input logic sel, input int exp);
        int n;
        n = 0;
        while (!(sel ? rce : sce) && n < 100) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (!(sel ? rce : sce) && n < 100);
        chk(n, exp);
    endtask

    task automatic do_reset(input logic pa, input logic pb);
        int md;
        @(posedge clock_i);
        #1;
        rst_n_i = 1'b0;
        pin_a = pa;
        pin_b = pb;
        repeat (20) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        repeat (2) @(posedge clock_i);
        md = {pb, pa};
        mdl.delete();
        mdl[0] = {CID, 6'h00, pb, pa, REV, VER};
        mdl[1] = {8'h00, 8'h08, 8'h02, 8'h04};
        mdl[6] = {6'h00, PLL_OD_BY_MODE[md*3 +: 3], 2'h0, PLL_F_BY_MODE[md*13 +: 13],
            1'h0, PLL_R_BY_MODE[md*7 +: 7]};
        mdl[8] = 32'h0000_0003;
        for (int a = 4; a < 40; a++) begin
            if (a != 6 && a != 8) mdl[a] = 32'h0000_0000;
        end
        for (int a = 0; a < 9; a++) br(a);
        br(12);
        br(13);
        chk({6'h00, od, 2'h0, f, 1'h0, r}, mdl[6]);
    endtask

    initial begin
        for (int m = 0; m < 4; m++) do_reset(m[0], m[1]);
        per(1'b0, 1);
        per(1'b1, 4);
        repeat (3) begin
            foreach (regs[i]) bw(regs[i], rnd());
            repeat (16) rt(16'(rnd()));
        end
        rt(mdl[5][15:0]);
        rt(mdl[5][15:0] ^ 16'h8000);
        rt(mdl[5][15:0] ^ 16'h0001);
        foreach (regs[i]) br(regs[i]);
        bw(7, 32'h0000_0002);
        bw(8, 32'h0000_0000);
        per(1'b0, 3);
        per(1'b1, 1);
        bw(4, 32'h0000_0001);
        chk(hs, 1'b1);
        bw(6, rnd());
        bw(4, 32'h0000_0101);
        bw(6, rnd());
        bw(4, 32'h8000_0000);
        chk(hs, 1'b0);
        bw(5, rnd());
        bw(4, 32'h0000_0000);
        br(4);
        br(5);
        do_reset(1'b0, 1'b1);
        end_of_test();
    end
endmodule
